/* File: common/seq_pkg.sv */
// Purpose: shared constants and types of the supply sequencer channel control
// Assumes: 100 MHz hclk, straps already resolved to logic codes
// Notes:   position codes: 0 = grounded, 1..8 = time position, F = tied to rail
package seq_pkg;
   localparam int          NCH           = 4;
   localparam int          CLK_MHZ       = 100;
   localparam int          NONE_WAIT_US  = 25;
   localparam logic [31:0] NONE_WAIT_CYC = 32'(NONE_WAIT_US * CLK_MHZ);
   localparam int          STEP_MIN_US   = 100;
   localparam logic [31:0] STEP_MIN_CYC  = 32'(STEP_MIN_US * CLK_MHZ);
   localparam logic [31:0] TMO_RESET     = 32'h0100_0000;

   localparam logic [3:0]  POS_FIRST     = 4'h1;
   localparam logic [3:0]  POS_LAST      = 4'h8;
   localparam logic [3:0]  CODE_OFF      = 4'h0;
   localparam logic [3:0]  CODE_FORCE    = 4'hF;

   localparam logic [1:0]  TRI_GND       = 2'h0;
   localparam logic [1:0]  TRI_OPEN      = 2'h1;
   localparam logic [1:0]  TRI_VCC       = 2'h2;

   // percent of the undervoltage threshold: 67 and 100
   localparam logic [7:0]  THR_67        = 8'h43;
   localparam logic [7:0]  THR_100       = 8'h64;

   localparam logic [7:0]  ADDR_STEP     = 8'h00;
   localparam logic [7:0]  ADDR_TMO      = 8'h04;
   localparam logic [7:0]  ADDR_STATUS   = 8'h08;
   localparam logic [7:0]  ADDR_CONFIG   = 8'h0C;

   localparam int          FLT_SEQ       = 0;
   localparam int          FLT_CMD       = 1;
   localparam int          FLT_RST       = 2;
   localparam int          FLT_EXT       = 3;
   localparam logic [3:0]  FLT_EXT_MASK  = 4'h8;

   localparam int          ST_FLT_LSB    = 0;
   localparam int          ST_STATE_LSB  = 4;
   localparam int          ST_POS_LSB    = 8;
   localparam int          ST_ACT_LSB    = 12;
   localparam int          CF_MASTER     = 0;
   localparam int          CF_LAST       = 1;
   localparam int          CF_POSITIVE   = 2;
   localparam int          CF_THR_LSB    = 8;

   typedef enum logic [2:0] {
      S_IDLE, S_UP_STROBE, S_UP_GAP, S_MONITOR, S_DOWN_STROBE, S_DOWN_GAP, S_FAULT
   } seq_state_t;
endpackage

/* File: rtl/supply_channel.sv */
// Purpose: one supply channel: position capture, off latch, gate and good outputs
// Assumes: control strobes come from the sequencer core; capture and forcing are decoded combinationally from on_cmd
// Notes:   gate and good are registered, one cycle behind the core state
`timescale 1ns/1ps
module supply_channel (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic [3:0] position_code,
   input  wire logic       capture,
   input  wire logic       running,
   input  wire logic       forcing,
   input  wire logic       fault_off,
   input  wire logic       up_phase,
   input  wire logic       down_phase,
   input  wire logic       monitor,
   input  wire logic [3:0] cur_pos,
   input  wire logic       above_up,
   input  wire logic       above_uv,
   output logic            supply_gate,
   output logic            channel_good_output,
   output logic            active,
   output logic            in_pos
);
   import seq_pkg::*;

   typedef struct packed {
      logic [3:0] pos;
      logic       off;
      logic       gate;
      logic       good;
   } chan_state_t;

   chan_state_t s;
   chan_state_t next_s;
   logic        forced;
   logic        enabled;

   always_comb begin
      next_s  = s;
      forced  = forcing && (position_code == CODE_FORCE);
      if (capture) begin
         // codes outside 1..8 at start leave the channel masked
         next_s.pos = position_code;
         next_s.off = (position_code == CODE_OFF) || (position_code > POS_LAST);
      end else if (running && position_code == CODE_OFF) begin
         next_s.off = 1'b1;
      end
      enabled = !s.off && !fault_off &&
                ((up_phase && s.pos <= cur_pos) || monitor ||
                 (down_phase && s.pos < cur_pos));
      next_s.gate = forced || (enabled && !next_s.off);
      next_s.good = forced ? above_up : (monitor && !s.off && above_uv);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '{pos: CODE_OFF, off: 1'b1, gate: 1'b0, good: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   assign supply_gate         = s.gate;
   assign channel_good_output = s.good;
   assign active              = !s.off;
   assign in_pos              = running && !s.off && (s.pos == cur_pos);

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   off_gate_low_a: assert property (
      (running && !capture && position_code == CODE_OFF) |=> s.off ##1 !supply_gate)
      else $error("async off channel still gated");
   off_stays_a: assert property (
      (s.off && !capture) |=> s.off)
      else $error("off channel re-enabled without new sequence");
   force_good_a: assert property (
      (forcing && position_code == CODE_FORCE) |=> channel_good_output == $past(above_up))
      else $error("forced channel good does not follow up threshold");
endmodule

/* File: rtl/supply_sequencer_channel_control.sv */
// Purpose: four channel supply sequencer core with AHB-Lite register slave
// Assumes: comparator results and straps arrive as synchronous logic levels
// Notes:   zero wait state slave; every transfer answers OKAY
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
module supply_sequencer_channel_control #(
   parameter logic [31:0] STEP_DEFAULT = seq_pkg::STEP_MIN_CYC
) (
   input  wire logic                     hclk,
   input  wire logic                     hresetn,
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic                          hreadyout,
   output logic                          hresp,
   output logic [31:0]                   hrdata,
   input  wire logic                     on_cmd,
   input  wire logic [seq_pkg::NCH*4-1:0] position_select_input,
   input  wire logic [1:0]               role_select_a,
   input  wire logic [1:0]               role_select_b,
   input  wire logic [1:0]               threshold_select_a,
   input  wire logic [1:0]               threshold_select_b,
   input  wire logic                     polarity_select,
   input  wire logic                     done_pullup_sense,
   input  wire logic [seq_pkg::NCH-1:0]  mon_above_up,
   input  wire logic [seq_pkg::NCH-1:0]  mon_above_uv,
   input  wire logic [seq_pkg::NCH-1:0]  mon_below_down,
   input  wire logic [seq_pkg::NCH-1:0]  mon_over,
   input  wire logic                     shutdown_fault_line_in,
   output logic                          shutdown_fault_line_out,
   output logic                          shutdown_fault_line_oe_n,
   output logic [seq_pkg::NCH-1:0]       supply_gate,
   output logic [seq_pkg::NCH-1:0]       channel_good_output,
   output logic                          reset_out_n,
   output logic                          excess_level_alarm_n,
   output logic                          position_strobe,
   output logic                          sequence_complete_n,
   output logic [3:0]                    fault_report,
   output logic [7:0]                    seq_threshold_pct,
   output logic                          monitor_positive
);
   import seq_pkg::*;

   typedef struct packed {
      seq_state_t  st;
      logic [3:0]  cur;
      logic [31:0] timer;
      logic [31:0] step;
      logic [31:0] tmo;
      logic [3:0]  log;
      logic [3:0]  report;
      logic        wr_pend;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
      logic        strobe;
      logic        done_n;
      logic        rst_n;
      logic        ov_n;
      logic        flt_oe_n;
      logic        master_first;
      logic        is_last;
      logic [7:0]  thr;
      logic        positive;
   } core_state_t;

   localparam core_state_t RESET_S = '{
      st: S_IDLE, cur: POS_FIRST, timer: '0, step: STEP_DEFAULT, tmo: TMO_RESET,
      log: '0, report: '0, wr_pend: 1'b0, wr_addr: '0, rdata: '0,
      strobe: 1'b1, done_n: 1'b1, rst_n: 1'b0, ov_n: 1'b1, flt_oe_n: 1'b1,
      master_first: 1'b0, is_last: 1'b0, thr: THR_100, positive: 1'b1};

   core_state_t    s;
   core_state_t    next_s;
   logic [NCH-1:0] force_mask;
   logic [NCH-1:0] active;
   logic [NCH-1:0] in_pos;
   logic           forcing;
   logic           running;
   logic           capture;
   logic           any_in;
   logic           up_reached;
   logic           down_reached;
   logic           rst_level;
   logic           all_below;
   logic           sel_ok;
   logic           step_done;
   logic           none_done;
   logic [3:0]     new_flt;

   genvar gi;
   generate
      for (gi = 0; gi < NCH; gi++) begin : g_ch
         assign force_mask[gi] = position_select_input[gi*4 +: 4] == CODE_FORCE;
         supply_channel u_ch (
            .hclk                (hclk),
            .hresetn             (hresetn),
            .position_code       (position_select_input[gi*4 +: 4]),
            .capture             (capture),
            .running             (running),
            .forcing             (forcing),
            .fault_off           (s.st == S_FAULT),
            .up_phase            (s.st == S_UP_STROBE || s.st == S_UP_GAP),
            .down_phase          (s.st == S_DOWN_STROBE || s.st == S_DOWN_GAP),
            .monitor             (s.st == S_MONITOR),
            .cur_pos             (s.cur),
            .above_up            (mon_above_up[gi]),
            .above_uv            (mon_above_uv[gi]),
            .supply_gate         (supply_gate[gi]),
            .channel_good_output (channel_good_output[gi]),
            .active              (active[gi]),
            .in_pos              (in_pos[gi])
         );
      end
   endgenerate

   function automatic logic [31:0] read_word(input logic [7:0] a);
      logic [31:0] w;
      w = 32'h0000_0000;
      // forward a write still in its data phase so back to back read sees it
      if (a == ADDR_STEP) begin
         w = (s.wr_pend && s.wr_addr == ADDR_STEP) ? hwdata : s.step;
      end else if (a == ADDR_TMO) begin
         w = (s.wr_pend && s.wr_addr == ADDR_TMO) ? hwdata : s.tmo;
      end else if (a == ADDR_STATUS) begin
         w = (32'(s.report) << ST_FLT_LSB) | (32'(s.st) << ST_STATE_LSB) |
             (32'(s.cur) << ST_POS_LSB) | (32'(active) << ST_ACT_LSB);
      end else if (a == ADDR_CONFIG) begin
         w = (32'(s.master_first) << CF_MASTER) | (32'(s.is_last) << CF_LAST) |
             (32'(s.positive) << CF_POSITIVE) | (32'(s.thr) << CF_THR_LSB);
      end
      return w;
   endfunction

   always_comb begin
      next_s       = s;
      running      = s.st inside {S_UP_STROBE, S_UP_GAP, S_MONITOR,
                                  S_DOWN_STROBE, S_DOWN_GAP};
      forcing      = !on_cmd && s.st == S_IDLE && (|force_mask);
      any_in       = |in_pos;
      up_reached   = &(~in_pos | mon_above_up);
      down_reached = &(~in_pos | mon_below_down);
      rst_level    = &(~active | mon_above_uv);
      all_below    = &mon_below_down;
      step_done    = (33'(s.timer) + 33'h1) >= 33'(s.step);
      none_done    = (33'(s.timer) + 33'h1) >= 33'(NONE_WAIT_CYC);
      sel_ok       = hsel && hready && htrans[1];

      // external faults are seen even while forcing; our own drive is masked
      new_flt          = 4'h0;
      new_flt[FLT_EXT] = !shutdown_fault_line_in && s.flt_oe_n;
      new_flt[FLT_SEQ] = !forcing && (s.st == S_UP_STROBE || s.st == S_DOWN_STROBE) &&
                         any_in && s.timer >= s.tmo;
      new_flt[FLT_CMD] = !forcing && (s.st == S_DOWN_STROBE || s.st == S_DOWN_GAP) &&
                         on_cmd;
      new_flt[FLT_RST] = !forcing && s.st == S_MONITOR && s.master_first &&
                         on_cmd && !rst_level;
      capture = s.st == S_IDLE && on_cmd && new_flt == 4'h0;

      unique case (s.st)
         S_IDLE: begin
            next_s.master_first = role_select_a == TRI_GND &&
                                  role_select_b == TRI_GND;
            next_s.is_last      = done_pullup_sense;
            next_s.thr          = (threshold_select_a == TRI_GND &&
                                   threshold_select_b == TRI_VCC) ? THR_67 : THR_100;
            next_s.positive     = !polarity_select;
            if (capture) begin
               next_s.st    = S_UP_STROBE;
               next_s.cur   = POS_FIRST;
               next_s.timer = '0;
               next_s.log   = 4'h0;
            end
         end
         S_UP_STROBE, S_UP_GAP, S_MONITOR: begin
            next_s.timer = s.timer + 32'h1;
            if (!on_cmd) begin
               next_s.st    = S_DOWN_STROBE;
               next_s.cur   = POS_LAST;
               next_s.timer = '0;
            end else if (s.st == S_UP_STROBE && (any_in ? up_reached : none_done)) begin
               next_s.st    = S_UP_GAP;
               next_s.timer = '0;
            end else if (s.st == S_UP_GAP && step_done) begin
               next_s.timer = '0;
               if (s.cur == POS_LAST) begin
                  next_s.st = S_MONITOR;
               end else begin
                  next_s.st  = S_UP_STROBE;
                  next_s.cur = s.cur + 4'h1;
               end
            end else if (s.st == S_MONITOR) begin
               next_s.timer = '0;
            end
         end
         S_DOWN_STROBE: begin
            next_s.timer = s.timer + 32'h1;
            if (any_in ? down_reached : none_done) begin
               next_s.st    = S_DOWN_GAP;
               next_s.timer = '0;
            end
         end
         S_DOWN_GAP: begin
            next_s.timer = s.timer + 32'h1;
            if (step_done) begin
               next_s.timer = '0;
               if (s.cur == POS_FIRST) begin
                  next_s.st = S_IDLE;
               end else begin
                  next_s.st  = S_DOWN_STROBE;
                  next_s.cur = s.cur - 4'h1;
               end
            end
         end
         S_FAULT: begin
            if (!on_cmd && all_below) begin
               next_s.st = S_IDLE;
            end
         end
         default: next_s.st = S_IDLE;
      endcase

      // set wins: the log only grows until a fresh sequence-up begins
      next_s.log = next_s.log | new_flt;
      if ((|new_flt) && s.st != S_FAULT) begin
         next_s.st    = S_FAULT;
         next_s.timer = '0;
      end
      next_s.report = forcing ? (s.log & FLT_EXT_MASK) : s.log;

      next_s.strobe   = !(next_s.st == S_UP_STROBE || next_s.st == S_DOWN_STROBE);
      next_s.done_n   = !(next_s.st inside {S_MONITOR, S_DOWN_STROBE, S_DOWN_GAP});
      next_s.flt_oe_n = next_s.st != S_FAULT;
      next_s.ov_n     = !(|mon_over);
      if (s.st == S_MONITOR) begin
         next_s.rst_n = on_cmd && rst_level;
      end else if (s.st == S_IDLE || s.st == S_FAULT) begin
         next_s.rst_n = s.thr == THR_100 && (&mon_above_uv);
      end else begin
         next_s.rst_n = 1'b0;
      end

      next_s.wr_pend = sel_ok && hwrite;
      next_s.wr_addr = haddr[7:0];
      if (s.wr_pend && s.wr_addr == ADDR_STEP) begin
         next_s.step = hwdata;
      end
      if (s.wr_pend && s.wr_addr == ADDR_TMO) begin
         next_s.tmo = hwdata;
      end
      if (sel_ok && !hwrite) begin
         next_s.rdata = read_word(haddr[7:0]);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= RESET_S;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout                = 1'b1;
   assign hresp                    = 1'b0;
   assign hrdata                   = s.rdata;
   assign shutdown_fault_line_out  = 1'b0;
   assign shutdown_fault_line_oe_n = s.flt_oe_n;
   assign reset_out_n              = s.rst_n;
   assign excess_level_alarm_n     = s.ov_n;
   assign position_strobe          = s.strobe;
   assign sequence_complete_n      = s.done_n;
   assign fault_report             = s.report;
   assign seq_threshold_pct        = s.thr;
   assign monitor_positive         = s.positive;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   force_gate_a: assert property (
      forcing |=> supply_gate == $past(force_mask))
      else $error("forced gates do not match rail selects");
   force_nofault_a: assert property (
      forcing |=> (s.log & ~$past(s.log) & ~FLT_EXT_MASK) == 4'h0)
      else $error("internal fault logged while forcing");
   fault_clear_a: assert property (
      (s.st == S_FAULT ##1 s.st != S_FAULT) |-> $past(!on_cmd && all_below))
      else $error("fault left without clear condition");
   rst_fault_a: assert property (
      (s.st == S_MONITOR && on_cmd && s.master_first && !rst_level)
         |=> s.log[FLT_RST] && s.st == S_FAULT)
      else $error("reset fault not raised in monitor phase");
   down_start_a: assert property (
      (s.st == S_MONITOR && !on_cmd && new_flt == 4'h0)
         |=> s.st == S_DOWN_STROBE && s.cur == POS_LAST ##1 !position_strobe)
      else $error("sequence down did not start at last position");
   down_drop_a: assert property (
      (s.st == S_MONITOR && !on_cmd) |=> ##1 (channel_good_output == '0 && !reset_out_n))
      else $error("good or reset still high after down command");
   empty_wait_a: assert property (
      (s.st == S_UP_STROBE && !any_in && on_cmd && new_flt == 4'h0 && !none_done)
         |=> s.st == S_UP_STROBE)
      else $error("empty position released before wait");
   gap_hold_a: assert property (
      (s.st == S_UP_GAP && on_cmd && new_flt == 4'h0 && !step_done)
         |=> s.st == S_UP_GAP && position_strobe)
      else $error("strobe high phase shorter than step period");
   report_hide_a: assert property (
      forcing |=> fault_report == ($past(s.log) & FLT_EXT_MASK))
      else $error("stored faults reported during forcing");
   alarm_free_a: assert property (
      (|mon_over) |=> !excess_level_alarm_n)
      else $error("excess alarm missed");

   reach_monitor_c: cover property (s.st == S_UP_GAP ##1 s.st == S_MONITOR);
   forcing_c: cover property (forcing ##1 forcing);
   fault_clear_c: cover property (s.st == S_FAULT ##1 s.st == S_IDLE);
   full_down_c: cover property (s.st == S_DOWN_GAP && s.cur == POS_FIRST ##1 s.st == S_IDLE);
endmodule

/* File: tb/supply_model.sv */
// Purpose: supplies behind the four gates, ramping with the gate
// Assumes: levels step once a clock
// Notes:   up 4, uv 6, down 0 of a 0..7 ramp
`timescale 1ns/1ps
module supply_model (
   input  wire logic       hclk,
   input  wire logic [3:0] gate,
   input  wire logic       ov,
   output logic      [3:0] above_up,
   output logic      [3:0] above_uv,
   output logic      [3:0] below_down,
   output logic      [3:0] over
);
   logic [2:0] lvl [4];
   initial for (int i = 0; i < 4; i++) lvl[i] = 3'h0;
   always @(posedge hclk) begin
      for (int i = 0; i < 4; i++) begin
         if (gate[i] && lvl[i] != 3'h7) lvl[i] <= lvl[i] + 3'h1;
         else if (!gate[i] && lvl[i] != 3'h0) lvl[i] <= lvl[i] - 3'h1;
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         above_up[i]   = lvl[i] >= 3'h4;
         above_uv[i]   = lvl[i] >= 3'h6;
         below_down[i] = lvl[i] == 3'h0;
      end
   end
   assign over = {4{ov}};
endmodule

/* File: tb/testbench.sv */
// Purpose: bench for the supply sequencer channel control
// Assumes: supply model ramps with its gate
// Notes:   step shortened to 20 cycles to keep runs short
`timescale 1ns/1ps
module testbench;
   import seq_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, on_cmd, ov, hready, hresp, fo, foe_n, fin;
   logic        rst_n, alarm_n, strobe, done_n, mpos, ext;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [15:0] psel;
   logic [8:0]  cfg;
   logic [7:0]  thr;
   logic [3:0]  gate, good, up, uv, dn, over, frep;
   int          failures, checks, cyc, falls;
   // released line floats up through its pull-up
   assign fin = foe_n ? !ext : fo;
   supply_sequencer_channel_control #(.STEP_DEFAULT(32'h14)) i_supply_sequencer_channel_control (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .on_cmd(on_cmd), .position_select_input(psel),
      .role_select_a(cfg[8:7]), .role_select_b(cfg[6:5]), .threshold_select_a(cfg[4:3]),
      .threshold_select_b(cfg[2:1]), .polarity_select(cfg[0]), .done_pullup_sense(1'b1),
      .mon_above_up(up), .mon_above_uv(uv), .mon_below_down(dn), .mon_over(over),
      .shutdown_fault_line_in(fin), .shutdown_fault_line_out(fo),
      .shutdown_fault_line_oe_n(foe_n), .supply_gate(gate), .channel_good_output(good),
      .reset_out_n(rst_n), .excess_level_alarm_n(alarm_n), .position_strobe(strobe),
      .sequence_complete_n(done_n), .fault_report(frep), .seq_threshold_pct(thr),
      .monitor_positive(mpos));
   supply_model i_supply_model (.hclk(hclk), .gate(gate), .ov(ov), .above_up(up),
      .above_uv(uv), .below_down(dn), .over(over));
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task close_out;
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(negedge strobe) if (hresetn) falls++;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         failures++;
         close_out();
      end
   end
   initial begin
      {hresetn, hsel, htrans, haddr, hwrite, hwdata, on_cmd, ov, psel, ext} = '0;
      {failures, checks, cyc, falls} = '0;
      cfg = 9'h004;
      void'($urandom(32'h33d4));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b1, ADDR_STEP, 32'h14);
      ahb(1'b0, ADDR_STEP, 32'h0);
      chk(q, 32'h14);
      ahb(1'b0, 32'h10, 32'h0);
      chk(q, 32'h0);
      ahb(1'b0, ADDR_CONFIG, 32'h0);
      chk(q[15:0], {THR_67, 8'h07});
      // channel 3 stays grounded, so it is masked
      psel <= {4'h0, 4'($urandom_range(1, 8)), 4'($urandom_range(1, 8)), 4'h1};
      repeat (2) @(posedge hclk);
      on_cmd <= 1'b1;
      do @(posedge hclk); while (done_n !== 1'b0);
      repeat (10) @(posedge hclk);
      chk(falls, 8);
      chk(gate, 4'h7);
      chk(good, 4'h7);
      psel[3:0] <= 4'h0;
      repeat (4) @(posedge hclk);
      chk(gate, 4'h6);
      psel[3:0] <= 4'h1;
      repeat (6) @(posedge hclk);
      chk(gate, 4'h6);
      on_cmd <= 1'b0;
      repeat (3) @(posedge hclk);
      chk({rst_n, good}, 5'h0);
      do @(posedge hclk); while (done_n !== 1'b1);
      chk({falls, gate, frep}, {32'd16, 8'h0});
      psel <= 16'hFFFF;
      repeat (12) @(posedge hclk);
      chk({gate, good[0], frep}, 9'h1F0);
      ov <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(alarm_n, 1'b0);
      // an outside fault pulled in while forcing must still be logged
      ext <= 1'b1;
      repeat (3) @(posedge hclk);
      chk(frep, FLT_EXT_MASK);
      close_out();
   end
endmodule
